//--- logic/rtss_pkg.sv
package rtss_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_SPEED = 32'h0000_0004;
    localparam logic [31:0] ADDR_SW12 = 32'h0000_0008;
    localparam logic [31:0] ADDR_SW23 = 32'h0000_000C;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
    // control word fields
    localparam int CTRL_MODE_BIT4 = 0;
    localparam int CTRL_ALTGEAR_BIT5 = 1;
    localparam int CTRL_LATHE = 2;
    localparam int CTRL_OLD_VARIANT = 3;
    localparam int CTRL_CSS_OPT = 4;
    localparam int CTRL_INT_GEAR = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [15:0] SW12_RESET = 16'h0FA0;
    localparam logic [15:0] SW23_RESET = 16'h1F40;
    localparam logic [31:0] SCAN_TIME_NS = 32'd8000;
    localparam logic [31:0] CLK_PERIOD_NS = 32'd25;
    localparam logic [31:0] SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
    typedef struct packed {
        logic tap_mode_req_primary;
        logic tap_mode_req_alt;
        logic spindle_sel_first;
        logic spindle_sel_second;
        logic gear_flag_low;
        logic gear_flag_high;
        logic gear_flag_low_alt;
        logic gear_flag_high_alt;
        logic second_spindle_gear_flag;
    } rtss_flags_s;
    typedef struct packed {
        logic tap_active;
        logic on_second;
        logic [1:0] gear_row;
        logic gear_stage_out_one;
        logic gear_stage_out_two;
        logic gear_stage_out_three;
    } rtss_result_s;
endpackage

//--- logic/rtss_top.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module rtss_top #(
    parameter int SCAN_CYC = 320
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [8:0] FLAGS_I,
    output logic TAP_ACTIVE_O,
    output logic SPINDLE_SECOND_O,
    output logic [1:0] GEAR_ROW_O,
    output logic GEAR_STAGE_OUT_ONE_O,
    output logic GEAR_STAGE_OUT_TWO_O,
    output logic GEAR_STAGE_OUT_THREE_O,
    output logic SCAN_STROBE_O
);
    logic [8:0] sync1, sync2, sync3, stable;
    logic [8:0] next_stable;
    logic [5:0] ctrl, next_ctrl;
    logic [15:0] speed, next_speed, sw12, next_sw12, sw23, next_sw23;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready, pslverr, next_pslverr;
    logic [15:0] scan_cnt, next_scan_cnt;
    logic strobe, next_strobe;
    rtss_pkg::rtss_flags_s snap, next_snap;
    rtss_pkg::rtss_result_s res, next_res;
    logic acc, done;
    logic upd, next_upd;

    // pin synchroniser, change taken when stages two and three agree
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            next_stable[i] = (sync2[i] == sync3[i]) ? sync3[i] : stable[i];
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            sync1 <= 9'h000;
            sync2 <= 9'h000;
            sync3 <= 9'h000;
            stable <= 9'h000;
        end else begin
            sync1 <= FLAGS_I;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
        end
    end

    // apb slave, one wait state; writes land on the edge that sees ready high
    assign acc = PSEL_I && PENABLE_I && !pready;
    assign done = PSEL_I && PENABLE_I && pready;
    always_comb begin
        next_ctrl = ctrl;
        next_speed = speed;
        next_sw12 = sw12;
        next_sw23 = sw23;
        next_prdata = prdata;
        next_pready = acc;
        next_pslverr = 1'b0;
        if (acc) begin
            next_prdata = 32'h0000_0000;
            case (PADDR_I)
                rtss_pkg::ADDR_CTRL: begin
                    next_prdata = {26'h0, ctrl};
                end
                rtss_pkg::ADDR_SPEED: begin
                    next_prdata = {16'h0, speed};
                end
                rtss_pkg::ADDR_SW12: begin
                    next_prdata = {16'h0, sw12};
                end
                rtss_pkg::ADDR_SW23: begin
                    next_prdata = {16'h0, sw23};
                end
                rtss_pkg::ADDR_STATUS: begin
                    next_pslverr = PWRITE_I;
                    next_prdata = {25'h0, res};
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (done && PWRITE_I) begin
            case (PADDR_I)
                rtss_pkg::ADDR_CTRL: begin
                    next_ctrl = PWDATA_I[5:0];
                end
                rtss_pkg::ADDR_SPEED: begin
                    next_speed = PWDATA_I[15:0];
                end
                rtss_pkg::ADDR_SW12: begin
                    next_sw12 = PWDATA_I[15:0];
                end
                rtss_pkg::ADDR_SW23: begin
                    next_sw23 = PWDATA_I[15:0];
                end
                default: begin
                end
            endcase
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            ctrl <= rtss_pkg::CTRL_RESET;
            speed <= rtss_pkg::SPEED_RESET;
            sw12 <= rtss_pkg::SW12_RESET;
            sw23 <= rtss_pkg::SW23_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            speed <= next_speed;
            sw12 <= next_sw12;
            sw23 <= next_sw23;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // scan tick; flags snapshot once per scan
    always_comb begin
        next_strobe = (scan_cnt == SCAN_CYC[15:0] - 16'h0001);
        next_scan_cnt = next_strobe ? 16'h0000 : scan_cnt + 16'h0001;
        next_snap = strobe ? rtss_pkg::rtss_flags_s'(stable) : snap;
        next_upd = strobe;
    end

    // decode of one scan's flags
    always_comb begin
        logic lathe, m4, m5, req_p, req_a, g_lo, g_hi;
        lathe = ctrl[rtss_pkg::CTRL_LATHE];
        m4 = ctrl[rtss_pkg::CTRL_MODE_BIT4];
        m5 = ctrl[rtss_pkg::CTRL_ALTGEAR_BIT5];
        req_a = snap.tap_mode_req_alt && (lathe || !m4);
        req_p = snap.tap_mode_req_primary && m4 && !lathe;
        g_lo = 1'b0;
        g_hi = 1'b0;
        if (m5 || (!lathe && ctrl[rtss_pkg::CTRL_CSS_OPT])) begin
            g_lo = snap.gear_flag_low_alt;
            g_hi = snap.gear_flag_high_alt;
        end else if (!ctrl[rtss_pkg::CTRL_OLD_VARIANT] || lathe) begin
            g_lo = snap.gear_flag_low;
            g_hi = snap.gear_flag_high;
        end
        next_res = '0;
        next_res.tap_active = req_a || req_p;
        if (snap.spindle_sel_first) begin
            next_res.on_second = 1'b0;
        end else begin
            next_res.on_second = snap.spindle_sel_second;
        end
        if (next_res.on_second) begin
            next_res.gear_row = {1'b0, snap.second_spindle_gear_flag};
        end else if (ctrl[rtss_pkg::CTRL_INT_GEAR]) begin
            if (speed < sw12) begin
                next_res.gear_row = 2'h0;
                next_res.gear_stage_out_one = 1'b1;
            end else if (speed < sw23) begin
                next_res.gear_row = 2'h1;
                next_res.gear_stage_out_two = 1'b1;
            end else begin
                next_res.gear_row = 2'h2;
                next_res.gear_stage_out_three = 1'b1;
            end
        end else begin
            next_res.gear_row = g_hi ? 2'h2 : (g_lo ? 2'h1 : 2'h0);
        end
        // outputs move only once per scan, after the snapshot
        if (!upd) next_res = res;
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            scan_cnt <= 16'h0000;
            strobe <= 1'b0;
            upd <= 1'b0;
            snap <= '0;
            res <= '0;
        end else begin
            scan_cnt <= next_scan_cnt;
            strobe <= next_strobe;
            upd <= next_upd;
            snap <= next_snap;
            res <= next_res;
        end
    end

    assign PRDATA_O = prdata;
    assign PREADY_O = pready;
    assign PSLVERR_O = pslverr;
    assign TAP_ACTIVE_O = res.tap_active;
    assign SPINDLE_SECOND_O = res.on_second;
    assign GEAR_ROW_O = res.gear_row;
    assign GEAR_STAGE_OUT_ONE_O = res.gear_stage_out_one;
    assign GEAR_STAGE_OUT_TWO_O = res.gear_stage_out_two;
    assign GEAR_STAGE_OUT_THREE_O = res.gear_stage_out_three;
    assign SCAN_STROBE_O = strobe;
endmodule

//--- tb/rtss_chk.sv
`timescale 1ns/1ps
module rtss_chk #(parameter int SCAN_CYC = 320) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic TAP_ACTIVE_O,
    input wire logic SPINDLE_SECOND_O,
    input wire logic [1:0] GEAR_ROW_O,
    input wire logic GEAR_STAGE_OUT_ONE_O,
    input wire logic GEAR_STAGE_OUT_TWO_O,
    input wire logic GEAR_STAGE_OUT_THREE_O,
    input wire logic SCAN_STROBE_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    logic [15:0] gap;
    logic [15:0] next_gap;
    logic [2:0] stg;
    assign stg = {GEAR_STAGE_OUT_ONE_O, GEAR_STAGE_OUT_TWO_O, GEAR_STAGE_OUT_THREE_O};
    // cycles since the last scan strobe
    always_comb next_gap = (RESET_I || SCAN_STROBE_O) ? 16'h0000 : gap + 16'h0001;
    always_ff @(posedge CLK_SYS_I) gap <= next_gap;
    sequence s_access; PSEL_I && PENABLE_I && !PREADY_O; endsequence
    sequence s_answer; PREADY_O ##1 !PREADY_O; endsequence
    a_ready_after_access: assert property (s_access |=> s_answer)
        else $error("ready missing after access phase");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
    a_read_upper_zero: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_scan_bound: assert property (gap <= SCAN_CYC) else $error("scan strobe late");
    a_out_on_scan: assert property ($changed({TAP_ACTIVE_O, SPINDLE_SECOND_O, GEAR_ROW_O, stg})
        |-> $past(SCAN_STROBE_O) || $past(SCAN_STROBE_O, 2)) else $error("output moved off scan");
    a_stage_onehot: assert property ($onehot0(stg)) else $error("gear stage not one-hot");
    a_second_no_stage: assert property (SPINDLE_SECOND_O |-> stg == 3'h0)
        else $error("stage reported on second spindle");
    a_second_row: assert property (TAP_ACTIVE_O && SPINDLE_SECOND_O |-> GEAR_ROW_O[1] == 1'b0)
        else $error("second spindle row out of range");
    a_row_range: assert property (GEAR_ROW_O != 2'h3) else $error("gear row three");
endmodule
bind rtss_top rtss_chk #(.SCAN_CYC(SCAN_CYC)) u_chk (.CLK_SYS_I, .RESET_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .TAP_ACTIVE_O, .SPINDLE_SECOND_O, .GEAR_ROW_O,
    .GEAR_STAGE_OUT_ONE_O, .GEAR_STAGE_OUT_TWO_O, .GEAR_STAGE_OUT_THREE_O, .SCAN_STROBE_O);

//--- tb/rtss_ctl_model.sv
`timescale 1ns/1ps
module rtss_ctl_model (
    input wire logic clk_i,
    input wire logic [8:0] want_i,
    output logic [8:0] flags_o,
    output logic fwd_rotate_req_o,
    output logic torque_limit_req_o
);
    logic [8:0] next_flags;
    always_comb next_flags = want_i;
    always_ff @(posedge clk_i) flags_o <= next_flags;
    assign fwd_rotate_req_o = flags_o[8] | flags_o[7];
    assign torque_limit_req_o = 1'h0;
endmodule

//--- tb/rtss_top_tb.sv
`timescale 1ns/1ps
module rtss_top_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [31:0] padr = 32'h0;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic [8:0] want = 9'h000;
    logic [8:0] flags;
    logic [5:0] c;
    logic [15:0] sp;
    logic [1:0] row, erow;
    logic er, tap, sec, s1, s2, s3, stb, rdy, serr, valid, gp, ga, e2;
    int error_cnt = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    rtss_ctl_model u_ctl (.clk_i(clk), .want_i(want), .flags_o(flags), .fwd_rotate_req_o(),
        .torque_limit_req_o());
    rtss_top #(.SCAN_CYC(4)) u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
        .PSLVERR_O(serr), .FLAGS_I(flags), .TAP_ACTIVE_O(tap), .SPINDLE_SECOND_O(sec),
        .GEAR_ROW_O(row), .GEAR_STAGE_OUT_ONE_O(s1), .GEAR_STAGE_OUT_TWO_O(s2),
        .GEAR_STAGE_OUT_THREE_O(s3), .SCAN_STROBE_O(stb));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task results;
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(negedge clk);
        while (rdy !== 1'h1) @(negedge clk);
        rd = prd;
        er = serr;
        @(posedge clk);
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    // outputs settle two cycles after the third strobe
    task scans;
        repeat (3) begin
            @(negedge clk);
            while (stb !== 1'h1) @(negedge clk);
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        void'($urandom(88256));
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        apb(1'h0, rtss_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'h0, rtss_pkg::ADDR_SW12, 32'h0);
        chk("sw12 reset", {16'h0, rtss_pkg::SW12_RESET}, rd);
        apb(1'h0, rtss_pkg::ADDR_SW23, 32'h0);
        chk("sw23 reset", {16'h0, rtss_pkg::SW23_RESET}, rd);
        apb(1'h0, 32'h14, 32'h0);
        chk("unmapped err", 32'h1, er);
        apb(1'h1, rtss_pkg::ADDR_STATUS, 32'hFF);
        chk("status ro err", 32'h1, er);
        for (int i = 0; i < 40; i++) begin
            c = 6'($urandom);
            sp = (i == 0) ? 16'h0F9F : (i == 1) ? 16'h0FA0 : (i == 2) ? 16'h1F40 : 16'($urandom);
            want <= 9'($urandom);
            apb(1'h1, rtss_pkg::ADDR_CTRL, {26'h0, c});
            apb(1'h1, rtss_pkg::ADDR_SPEED, {16'h0, sp});
            scans;
            valid = c[2] ? want[7] : (c[0] ? want[8] : want[7]);
            e2 = !want[6] && want[5];
            gp = !c[3] || (c[2] && !c[1]);
            ga = c[1] || (!c[2] && c[4]);
            erow = gp ? {want[3], want[4] & !want[3]} : ga ? {want[1], want[2] & !want[1]} : 2'h0;
            if (c[5]) erow = sp < 16'h0FA0 ? 2'h0 : sp < 16'h1F40 ? 2'h1 : 2'h2;
            if (e2) erow = want[0] ? 2'h1 : 2'h0;
            chk("tap", valid, tap);
            if (valid) begin
                chk("second", e2, sec);
                if (e2 || c[5] || !(gp && ga)) chk("row", erow, row);
                if (c[5] && !e2)
                    chk("stage", sp < 16'h0FA0 ? 3'h4 : sp < 16'h1F40 ? 3'h2 : 3'h1, {s1, s2, s3});
            end
        end
        results;
    end
    initial begin
        #100000;
        error_cnt++;
        results;
    end
endmodule
